// >>> rtl/acs_pkg.sv
// package: constants and types for the converter control block
package acs_pkg;
   // ------------------------------------------------------------
   // config field positions and reset values
   // ------------------------------------------------------------
   localparam int CFG_W = 16;
   localparam int CFG_ONE_SHOT_BIT = 15;
   localparam int CFG_MODE_BIT = 8;
   localparam int CFG_TEMP_BIT = 4;
   localparam int CFG_PULL_BIT = 3;
   localparam logic [15:0] CFG_RESET = 16'h058B;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam int RESULT_W = 16;
   localparam int TEMP_W = 14;
   localparam int FRAME_BITS = 32;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int IDLE_TIMEOUT_MS = 28;
   localparam int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int PRE_READY_US = 8;
   localparam int PRE_READY_CYC = PRE_READY_US * (CLK_HZ / 1_000_000);
   localparam int CONV_CYC_DEF = 2000;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {ST_DOWN, ST_CONV, ST_DONE} acs_conv_e;
   typedef struct packed {
      logic valid;
      logic [15:0] code;
   } acs_sample_s;
endpackage

// >>> rtl/acs_ctrl.sv
// converter mode control and serial port of the sigma-delta converter
//
// What this block does
// R01: temp_sensor_select set to 1 converts the internal temperature sensor.
// R02: temperature result is 14 bits, left-justified in the 16-bit word.
// R03: conversion words shift out most significant byte first.
// R04: temperature step is 0.03125 C, negatives in two's complement.
// R05: reset loads every configuration field with its default.
// R06: after start-up sit powered down, serial port stays active.
// R07: mode bit 1 selects single-shot with power-down between conversions.
// R08: one-shot write powers up, clears trigger, starts one conversion.
// R09: single-shot returns to power-down once the result is ready.
// R10: one-shot write during a conversion is ignored, not queued.
// R11: mode bit 0 stores each result and starts the next immediately.
// R12: writing mode 1 or reset leaves continuous mode.
// R13: four-wire port, or three-wire with select tied low.
// R14: select high resets the port, ignores clock, floats the output.
// R15: select falling drives output low if unread data, else high.
// R16: result copied to shift register at transfer start, held unchanged.
// R17: clock low for 28 ms resets the serial port.
// R18: serial input sampled on falling clock edge, never driven.
// R19: output changes on each rising clock edge while shifting.
// R20: output goes low when a new result is ready.
// R21: continuous mode: output high 8 us before next ready if unread.
// R22: host finishes reading before output returns high.
// R23: result register holds 0 until first conversion completes.
// R24: bit 15 appears on the first rising clock edge of a transfer.
// R25: single-shot completion signals ready like continuous mode.
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl
   import acs_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYC_DEF,
   parameter int TIMEOUT_CYC = IDLE_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   // serial pins
   input wire logic I_CS_N,
   input wire logic I_SCLK,
   input wire logic I_DIN,
   output logic O_DATA_OUT_READY_N,
   output logic O_DATA_OUT_READY_N_OE_N,
   output logic O_DATA_OUT_READY_N_PULL,
   // analog front end
   input wire logic [15:0] I_ADC_CODE,
   input wire logic [13:0] I_TEMP_CODE,
   // status
   output logic O_POWERED,
   output logic O_TEMP_SENSOR_SELECT,
   output logic [15:0] O_CONFIG,
   output logic [15:0] O_RESULT
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] cs_s;
      logic [1:0] sck_s;
      logic [1:0] din_s;
      logic sck_d;
      logic cs_d;
      acs_conv_e conv;
      logic [31:0] conv_cnt;
      logic [15:0] cfg;
      acs_sample_s res;
      logic fresh;
      logic [31:0] shift;
      logic [15:0] din_sr;
      logic [5:0] bits;
      logic active;
      logic dout;
      logic [31:0] idle_cnt;
   } acs_state_s;

   acs_state_s r;
   acs_state_s next_r;
   logic cs_n;
   logic sck_rise;
   logic sck_fall;
   logic [15:0] sample;
   logic [15:0] wr_cfg;

   assign cs_n = r.cs_s[1];
   // cs high ignores the clock entirely
   assign sck_rise = !cs_n && r.sck_s[1] && !r.sck_d; // R14
   assign sck_fall = !cs_n && !r.sck_s[1] && r.sck_d; // R18

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_r = r;
      // two-flop sync of all pins, first flop read only here
      next_r.cs_s = {r.cs_s[0], I_CS_N};
      next_r.sck_s = {r.sck_s[0], I_SCLK};
      next_r.din_s = {r.din_s[0], I_DIN};
      next_r.sck_d = r.sck_s[1];
      next_r.cs_d = cs_n;
      sample = r.cfg[CFG_TEMP_BIT] ? {I_TEMP_CODE, 2'b00} : I_ADC_CODE; // R01 R02 R04
      wr_cfg = {r.din_sr[14:0], r.din_s[1]};

      // conversion engine
      case (r.conv)
         ST_DOWN: begin
            // powered down until trigger or continuous mode
            if (!r.cfg[CFG_MODE_BIT] || r.cfg[CFG_ONE_SHOT_BIT]) begin // R06 R07 R11
               next_r.conv = ST_CONV;
               next_r.conv_cnt = 32'h0;
               next_r.cfg[CFG_ONE_SHOT_BIT] = 1'b0; // R08
            end
         end
         ST_CONV: begin
            next_r.cfg[CFG_ONE_SHOT_BIT] = 1'b0; // R10
            next_r.conv_cnt = r.conv_cnt + 32'h1;
            // unread result: release ready shortly before the next one
            if (r.fresh && r.conv_cnt == 32'(CONV_CYC - PRE_READY_CYC)) begin // R21
               next_r.fresh = 1'b0;
            end
            if (r.conv_cnt >= 32'(CONV_CYC - 1)) begin
               next_r.conv = ST_DONE;
            end
         end
         ST_DONE: begin
            next_r.res.code = sample; // R23
            next_r.res.valid = 1'b1;
            next_r.fresh = 1'b1; // R20 R25
            next_r.conv_cnt = 32'h0;
            next_r.conv = r.cfg[CFG_MODE_BIT] ? ST_DOWN : ST_CONV; // R09 R11
         end
         default: begin
            next_r.conv = ST_DOWN;
         end
      endcase

      // serial port
      if (cs_n) begin
         next_r.active = 1'b0; // R14
         next_r.bits = 6'h0;
         next_r.idle_cnt = 32'h0;
      end else begin
         if (r.cs_d) begin
            next_r.dout = !r.fresh; // R15
         end
         // clock-low timeout resets the port
         if (r.sck_s[1]) begin
            next_r.idle_cnt = 32'h0;
         end else if (r.idle_cnt >= 32'(TIMEOUT_CYC - 1)) begin
            next_r.active = 1'b0; // R17
            next_r.bits = 6'h0;
         end else begin
            next_r.idle_cnt = r.idle_cnt + 32'h1;
         end
         if (sck_rise) begin
            if (!r.active) begin
               // lock result for the whole transfer, msb first
               next_r.shift = {r.res.code, r.cfg[15:1], 1'b1} << 1; // R16 R03
               next_r.dout = r.res.code[15]; // R24
               next_r.active = 1'b1;
               next_r.fresh = 1'b0;
            end else begin
               next_r.dout = r.shift[31]; // R19
               next_r.shift = {r.shift[30:0], 1'b0};
            end
         end
         if (sck_fall && r.active) begin
            next_r.din_sr = wr_cfg; // R18
            next_r.bits = r.bits + 6'h1;
            if (r.bits == 6'd15 && wr_cfg != 16'h0000 && wr_cfg != 16'hFFFF) begin
               // config write; reserved bit reads one, set beats clear on trigger
               next_r.cfg = {wr_cfg[15] | next_r.cfg[15], wr_cfg[14:1], 1'b1}; // R12 R08
               if (!wr_cfg[CFG_MODE_BIT] && r.cfg[CFG_MODE_BIT]) begin
                  next_r.cfg[CFG_ONE_SHOT_BIT] = 1'b0;
               end
               if (r.conv != ST_DOWN) begin
                  next_r.cfg[CFG_ONE_SHOT_BIT] = 1'b0; // R10
               end
            end
            if (r.bits == 6'(FRAME_BITS - 1)) begin
               next_r.active = 1'b0;
               next_r.bits = 6'h0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         r.cs_s <= 2'b11;
         r.sck_s <= 2'b00;
         r.din_s <= 2'b00;
         r.sck_d <= 1'b0;
         r.cs_d <= 1'b1;
         r.conv <= ST_DOWN; // R06
         r.conv_cnt <= 32'h0;
         r.cfg <= CFG_RESET; // R05 R12
         r.res <= '{valid: 1'b0, code: RESULT_RESET}; // R23
         r.fresh <= 1'b0;
         r.shift <= 32'h0;
         r.din_sr <= 16'h0;
         r.bits <= 6'h0;
         r.active <= 1'b0;
         r.dout <= 1'b1;
         r.idle_cnt <= 32'h0;
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // idle and cs low: pin tracks ready state; data while shifting
   assign O_DATA_OUT_READY_N = r.active ? r.dout : (r.cs_d ? 1'b1 : !r.fresh); // R15 R20
   assign O_DATA_OUT_READY_N_OE_N = cs_n; // R14 R13
   assign O_DATA_OUT_READY_N_PULL = cs_n && r.cfg[CFG_PULL_BIT];
   assign O_POWERED = (r.conv != ST_DOWN);
   assign O_TEMP_SENSOR_SELECT = r.cfg[CFG_TEMP_BIT];
   assign O_CONFIG = r.cfg;
   assign O_RESULT = r.res.code;
endmodule
`default_nettype wire

// >>> verification/acs_ctrl_props.sv
// checker: port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl_props
   import acs_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYC_DEF,
   parameter int TIMEOUT_CYC = IDLE_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   // serial pins
   input wire logic I_CS_N,
   input wire logic I_SCLK,
   input wire logic I_DIN,
   input wire logic O_DATA_OUT_READY_N,
   input wire logic O_DATA_OUT_READY_N_OE_N,
   input wire logic O_DATA_OUT_READY_N_PULL,
   // converter side and status
   input wire logic [15:0] I_ADC_CODE,
   input wire logic [13:0] I_TEMP_CODE,
   input wire logic O_POWERED,
   input wire logic O_TEMP_SENSOR_SELECT,
   input wire logic [15:0] O_CONFIG,
   input wire logic [15:0] O_RESULT
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);
   // three samples cover the two sync stages of the select pin
   sequence s_cs_high; I_CS_N [*3]; endsequence
   sequence s_cs_low; !I_CS_N [*3]; endsequence
   a_reset_defaults: assert property ($fell(I_RST) |-> O_CONFIG == CFG_RESET && O_RESULT == RESULT_RESET)
      else $error("config or result not at default after reset");
   a_idle_down: assert property ($fell(I_RST) |-> !O_POWERED [*8])
      else $error("converter powered right after reset");
   a_cs_float: assert property (s_cs_high |-> O_DATA_OUT_READY_N_OE_N)
      else $error("output driven while deselected");
   a_cs_drive: assert property (s_cs_low |-> !O_DATA_OUT_READY_N_OE_N)
      else $error("output not driven while selected");
   a_temp_view: assert property (O_TEMP_SENSOR_SELECT == O_CONFIG[CFG_TEMP_BIT])
      else $error("sensor select differs from config");
   a_temp_align: assert property ($changed(O_RESULT) && O_TEMP_SENSOR_SELECT |-> O_RESULT[1:0] == 2'h0)
      else $error("temperature result not left aligned");
   a_ss_clear: assert property ($rose(O_POWERED) |-> ##[0:2] !O_CONFIG[CFG_ONE_SHOT_BIT])
      else $error("one-shot trigger not cleared");
   a_ss_powerdown: assert property ($fell(O_POWERED) |-> O_CONFIG[CFG_MODE_BIT])
      else $error("power down outside single-shot mode");
   a_cont_run: assert property ((!O_CONFIG[CFG_MODE_BIT] && O_POWERED ##1 !O_CONFIG[CFG_MODE_BIT]) |-> O_POWERED)
      else $error("continuous mode stopped converting");
endmodule
bind acs_ctrl acs_ctrl_props #(.CONV_CYC(CONV_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) u_props (.*);
`default_nettype wire

// >>> verification/acs_host.sv
// host model: serial master driving select, clock and data in
`timescale 1ns/1ps
`default_nettype none
module acs_host (
   // bench clock
   input wire logic i_clk,
   // serial pins
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_din,
   input wire logic i_dout
);
   // low keeps select down between frames, three-wire use
   logic hold_cs;
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_din = 1'b0;
      hold_cs = 1'b1;
   end
   // ------------------------------------------------------------
   // one frame; config word sent twice for 32 bits
   // ------------------------------------------------------------
   task automatic xfer(input logic [15:0] w, input int n, output logic rdy, output logic [31:0] r);
      r = 32'h0;
      @(posedge i_clk) #1 o_cs_n = 1'b0;
      repeat (4) @(posedge i_clk);
      rdy = i_dout;
      // whole word read straight after select, before ready can drop again
      for (int i = 0; i < n; i++) begin
         #1 o_sclk = 1'b1;
         o_din = w[15 - (i % 16)];
         // half period of 8 clocks gives the 160 ns link clock
         repeat (8) @(posedge i_clk);
         #1 o_sclk = 1'b0;
         r = {r[30:0], i_dout};
         repeat (8) @(posedge i_clk);
      end
      #1 o_cs_n = hold_cs;
      // released data line must not keep its last value
      o_din = ~o_din;
   endtask
endmodule
`default_nettype wire

// >>> verification/acs_ctrl_tb.sv
// bench: random and corner checks of the converter control block
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl_tb;
   import acs_pkg::*;
   // conversion must outlast a frame so the second trigger lands mid-conversion,
   // and must exceed the 8 us early release so that release is exercised
   localparam int CONV = 1000;
   localparam int TMO = 500;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n, sclk, din, dout, oe_n, pull, powered, tsel, rdy;
   logic [15:0] adc = 16'h0000;
   logic [15:0] cfg, res;
   logic [13:0] temp = 14'h0000;
   logic [13:0] corner [2] = '{14'h3CE0, 14'h0008};
   logic [31:0] seed = 32'h06872582;
   logic [31:0] rd;
   int errors = 0;
   int check_count = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   acs_ctrl #(.CONV_CYC(CONV), .TIMEOUT_CYC(TMO)) uut (.I_REF_CLK(clk), .I_RST(rst), .I_CS_N(cs_n),
      .I_SCLK(sclk), .I_DIN(din), .O_DATA_OUT_READY_N(dout), .O_DATA_OUT_READY_N_OE_N(oe_n),
      .O_DATA_OUT_READY_N_PULL(pull), .I_ADC_CODE(adc), .I_TEMP_CODE(temp), .O_POWERED(powered),
      .O_TEMP_SENSOR_SELECT(tsel), .O_CONFIG(cfg), .O_RESULT(res));
   acs_host host (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_dout(dout));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [15:0] word(input logic ss, input logic mode, input logic ts);
      return {ss, 3'h0, 3'h2, mode, 3'h4, ts, 4'hB};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic new_adc;
      seed = xs(seed);
      @(posedge clk) #1 adc = seed[15:0];
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         errors++;
         stop_test;
      end
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      repeat (200) @(posedge clk);
      check(cfg, CFG_RESET);
      check(res, RESULT_RESET);
      check(powered, 1'b0);
      new_adc;
      host.xfer(word(1'b1, 1'b1, 1'b0), 32, rdy, rd);
      check(rdy, 1'b1);
      check(rd, {RESULT_RESET, CFG_RESET});
      check(cfg[CFG_ONE_SHOT_BIT], 1'b0);
      // second trigger lands while the first conversion still runs
      host.xfer(word(1'b1, 1'b1, 1'b0), 16, rdy, rd);
      check(powered, 1'b1);
      check(cfg[CFG_ONE_SHOT_BIT], 1'b0);
      repeat (CONV + 50) @(posedge clk);
      check(powered, 1'b0);
      check(res, adc);
      repeat (CONV + 100) @(posedge clk);
      check(powered, 1'b0);
      host.xfer(16'h0000, 16, rdy, rd);
      check(rdy, 1'b0);
      check(rd[15:0], adc);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         @(posedge clk) #1 temp = (i < 2) ? corner[i] : seed[13:0];
         host.xfer(word(1'b1, 1'b1, 1'b1), 16, rdy, rd);
         repeat (CONV + 50) @(posedge clk);
         host.xfer(16'h0000, 16, rdy, rd);
         check(tsel, 1'b1);
         check(rd[15:0], {temp, 2'h0});
      end
      new_adc;
      host.xfer(word(1'b0, 1'b0, 1'b0), 16, rdy, rd);
      repeat (CONV + 50) @(posedge clk);
      new_adc;
      repeat (CONV + 50) @(posedge clk);
      check(powered, 1'b1);
      check(res, adc);
      // unread result: ready low first, released well before the next one
      #1 adc = ~adc;
      @(res);
      check(res, adc);
      host.xfer(16'h0000, 0, rdy, rd);
      check(rdy, 1'b0);
      repeat (250) @(posedge clk);
      host.xfer(16'h0000, 0, rdy, rd);
      check(rdy, 1'b1);
      host.xfer(word(1'b0, 1'b1, 1'b0), 16, rdy, rd);
      repeat (CONV + 50) @(posedge clk);
      check(powered, 1'b0);
      host.hold_cs = 1'b0;
      new_adc;
      host.xfer(word(1'b1, 1'b1, 1'b0), 16, rdy, rd);
      repeat (CONV + 50) @(posedge clk);
      host.xfer(16'h0000, 5, rdy, rd);
      repeat (TMO + 100) @(posedge clk);
      host.xfer(16'h0000, 16, rdy, rd);
      check(rd[15:0], adc);
      stop_test;
   end
endmodule
`default_nettype wire
